// ===== ftm_pkg.sv
// Constants shared by the FIFO trigger and first interrupt pin mapping block
package ftm_pkg;
  // Register indices; the byte address is four times the index
  localparam logic [7:0] CNT_LO_IDX = 8'h29;
  localparam logic [7:0] MAP_IDX    = 8'h2A;
  localparam logic [7:0] CTRL_IDX   = 8'h30;
  localparam logic [7:0] STAT_IDX   = 8'h31;
  localparam logic [7:0] IEN_IDX    = 8'h32;
  localparam logic [7:0] ICLR_IDX   = 8'h33;
  localparam logic [7:0] INFO_IDX   = 8'h34;

  // Values after reset
  localparam logic [7:0] CNT_LO_RST = 8'h80;
  localparam logic [7:0] MAP_RST    = 8'h00;
  localparam logic [1:0] MODE_RST   = 2'h0;
  localparam logic [2:0] IRQ_RST    = 3'h0;

  // Field positions
  localparam int MAP_POL_BIT  = 7;
  localparam int MAP_AWAKE    = 6;
  localparam int MAP_INACT    = 5;
  localparam int MAP_ACT      = 4;
  localparam int MAP_OVR      = 3;
  localparam int MAP_WM       = 2;
  localparam int MAP_RDY      = 1;
  localparam int MAP_DATA     = 0;
  localparam int CTRL_MSB_BIT = 2;
  localparam int EV_WM        = 0;
  localparam int EV_ACT       = 1;
  localparam int EV_OVR       = 2;
  localparam int EV_W         = 3;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic [1:0] {
    FTM_OFF    = 2'h0,
    FTM_OLDEST = 2'h1,
    FTM_STREAM = 2'h2,
    FTM_TRIG   = 2'h3
  } ftm_mode_e;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_ARM  = 4'h2,
    ST_FILL = 4'h4,
    ST_DONE = 4'h8
  } ftm_trig_e;

  // Byte address of a register index
  function automatic logic [9:0] ftm_ba(input logic [7:0] idx);
    return {idx, 2'h0};
  endfunction
endpackage

// ===== ftm_core.sv
// FIFO trigger control, sample-set count and first interrupt pin mapping
//
// How it works
// - Mode code 11 runs the FIFO as a one-shot trigger around activity.
// - In triggered mode keep the 9-bit sample count as pre-event history.
// - After trigger, store the configured count, then raise the watermark.
// - No further watermark in triggered mode until the host reads the FIFO.
// - Count is in sample sets: entries equal count times enabled axes.
// - Any count from zero to 511 is accepted.
// - Low eight count bits are read/write and reset to 0x80.
// - Map bit 7 clear gives active-high pin, set gives active-low.
// - Map bit 6 routes the awake status to the first pin.
// - Map bit 5 routes the inactivity status to the first pin.
// - Map bit 4 routes the activity status to the first pin.
// - Map bit 3 routes the FIFO overrun status to the first pin.
// - Map bit 2 routes the watermark status to the first pin.
// - Map bit 1 routes the FIFO ready status to the first pin.
// - Map bit 0 routes the new-sample flag to the first pin.
// - Map register is read/write at its own address, cleared at reset.
// - Mode 00 disabled, 01 oldest saved, 10 stream; change only in standby (here the mode field takes a write at any time).
// - Ninth count bit is bit 2 of the FIFO control register.
//
// Our own choice: register access over AHB-Lite.
`timescale 1ns/1ps
module ftm_core #(
  parameter int CNT_W  = 9,
  parameter int ENT_W  = 11,
  parameter int ADDR_W = 8
) (
  input  wire logic              clk_sys_i,
  input  wire logic              nrst_i,
  input  wire logic              ce_i,
  input  wire logic              hsel_i,
  input  wire logic [ADDR_W-1:0] haddr_i,
  input  wire logic [1:0]        htrans_i,
  input  wire logic              hwrite_i,
  input  wire logic [2:0]        hsize_i,
  input  wire logic [31:0]       hwdata_i,
  input  wire logic              hready_i,
  output logic                   hreadyout_o,
  output logic                   hresp_o,
  output logic [31:0]            hrdata_o,
  input  wire logic              sample_entry_i,
  input  wire logic              activity_i,
  input  wire logic              act_status_i,
  input  wire logic              awake_i,
  input  wire logic              inact_i,
  input  wire logic              overrun_i,
  input  wire logic              fifo_ready_i,
  input  wire logic              data_ready_i,
  input  wire logic              fifo_read_i,
  input  wire logic [ENT_W-1:0]  fifo_level_i,
  input  wire logic [1:0]        axes_i,
  output logic [1:0]             fifo_mode_o,
  output logic [ENT_W-1:0]       entry_target_o,
  output logic                   fill_stop_o,
  output logic                   queue_level_reached_flag_o,
  output logic                   first_interrupt_pin_o,
  output logic                   irq_o
);

  typedef struct packed {
    logic [7:0]              cnt_lo;
    logic [7:0]              map;
    logic [1:0]              mode;
    logic                    cnt_msb;
    logic [ftm_pkg::EV_W-1:0] stat;
    logic [ftm_pkg::EV_W-1:0] ien;
    ftm_pkg::ftm_trig_e      st;
    logic [ENT_W-1:0]        pre;
    logic [ENT_W-1:0]        post;
    logic                    wm;
    logic                    pin;
    logic                    ovr_q;
    logic                    dp_act;
    logic                    dp_wr;
    logic [ADDR_W-1:0]       dp_addr;
    logic [31:0]             rdata;
  } ftm_state_s;

  localparam ftm_state_s RST = '{
    cnt_lo:  ftm_pkg::CNT_LO_RST,
    map:     ftm_pkg::MAP_RST,
    mode:    ftm_pkg::MODE_RST,
    cnt_msb: 1'b0,
    stat:    ftm_pkg::IRQ_RST,
    ien:     ftm_pkg::IRQ_RST,
    st:      ftm_pkg::ST_IDLE,
    pre:     '0,
    post:    '0,
    wm:      1'b0,
    pin:     1'b0,
    ovr_q:   1'b0,
    dp_act:  1'b0,
    dp_wr:   1'b0,
    dp_addr: '0,
    rdata:   32'h0000_0000
  };

  localparam logic [ADDR_W-1:0] A_CNT  = ADDR_W'(ftm_pkg::ftm_ba(ftm_pkg::CNT_LO_IDX));
  localparam logic [ADDR_W-1:0] A_MAP  = ADDR_W'(ftm_pkg::ftm_ba(ftm_pkg::MAP_IDX));
  localparam logic [ADDR_W-1:0] A_CTRL = ADDR_W'(ftm_pkg::ftm_ba(ftm_pkg::CTRL_IDX));
  localparam logic [ADDR_W-1:0] A_STAT = ADDR_W'(ftm_pkg::ftm_ba(ftm_pkg::STAT_IDX));
  localparam logic [ADDR_W-1:0] A_IEN  = ADDR_W'(ftm_pkg::ftm_ba(ftm_pkg::IEN_IDX));
  localparam logic [ADDR_W-1:0] A_ICLR = ADDR_W'(ftm_pkg::ftm_ba(ftm_pkg::ICLR_IDX));
  localparam logic [ADDR_W-1:0] A_INFO = ADDR_W'(ftm_pkg::ftm_ba(ftm_pkg::INFO_IDX));

  // Entries held for a count of sample sets
  function automatic logic [ENT_W-1:0] ftm_tgt(
    input logic       msb,
    input logic [7:0] lo,
    input logic [1:0] axes
  );
    logic [ENT_W-1:0] sets;
    sets = ENT_W'({msb, lo});
    return ENT_W'(sets * ENT_W'(axes));
  endfunction

  ftm_state_s r;
  ftm_state_s next_r;

  logic [ENT_W-1:0]         tgt;
  logic [ENT_W-1:0]         post_inc;
  logic [ftm_pkg::EV_W-1:0] ev;
  logic [ftm_pkg::EV_W-1:0] clr;
  logic [6:0]               src;
  logic [31:0]              rd;

  always_comb begin
    next_r = r;
    clr = '0;
    rd = 32'h0000_0000;

    // Data phase write; address was captured one cycle earlier
    if (r.dp_act && r.dp_wr) begin
      case (r.dp_addr)
        A_CNT: begin
          next_r.cnt_lo = hwdata_i[7:0];
        end
        A_MAP: begin
          next_r.map = hwdata_i[7:0];
        end
        A_CTRL: begin
          next_r.mode = hwdata_i[1:0];
          next_r.cnt_msb = hwdata_i[ftm_pkg::CTRL_MSB_BIT];
        end
        A_IEN: begin
          next_r.ien = hwdata_i[ftm_pkg::EV_W-1:0];
        end
        A_ICLR: begin
          clr = hwdata_i[ftm_pkg::EV_W-1:0];
        end
        default: begin
        end
      endcase
    end

    // Count always uses the live register, so a new count acts at once
    tgt = ftm_tgt(r.cnt_msb, r.cnt_lo, axes_i);
    post_inc = r.post + ENT_W'(sample_entry_i);

    // Triggered capture sequencer
    case (r.st)
      ftm_pkg::ST_IDLE: begin
        next_r.pre = '0;
        next_r.post = '0;
        if (r.mode == ftm_pkg::FTM_TRIG) begin
          next_r.st = ftm_pkg::ST_ARM;
        end
      end
      ftm_pkg::ST_ARM: begin
        // Pre-event history saturates at the target depth
        if (sample_entry_i && r.pre < tgt) begin
          next_r.pre = r.pre + ENT_W'(1);
        end
        if (activity_i) begin
          next_r.st = ftm_pkg::ST_FILL;
          next_r.post = '0;
        end
      end
      ftm_pkg::ST_FILL: begin
        next_r.post = post_inc;
        if (post_inc >= tgt) begin
          next_r.st = ftm_pkg::ST_DONE;
        end
      end
      ftm_pkg::ST_DONE: begin
        // One-shot: held until the host reads the FIFO
        if (fifo_read_i) begin
          next_r.st = ftm_pkg::ST_ARM;
          next_r.pre = '0;
          next_r.post = '0;
        end
      end
      default: begin
        next_r.st = ftm_pkg::ST_IDLE;
      end
    endcase
    if (r.mode != ftm_pkg::FTM_TRIG) begin
      next_r.st = ftm_pkg::ST_IDLE;
    end

    // Watermark status per mode
    case (r.mode)
      ftm_pkg::FTM_OFF: next_r.wm = 1'b0;
      ftm_pkg::FTM_TRIG: next_r.wm = (next_r.st == ftm_pkg::ST_DONE);
      default: next_r.wm = (fifo_level_i >= tgt);
    endcase

    // Sticky events; a set in the clearing cycle wins
    next_r.ovr_q = overrun_i;
    ev = '0;
    ev[ftm_pkg::EV_WM] = next_r.wm && !r.wm;
    ev[ftm_pkg::EV_ACT] = activity_i;
    ev[ftm_pkg::EV_OVR] = overrun_i && !r.ovr_q;
    next_r.stat = (r.stat & ~clr) | ev;

    // First pin sources, each placed at its own map bit
    src = '0;
    src[ftm_pkg::MAP_AWAKE] = awake_i;
    src[ftm_pkg::MAP_INACT] = inact_i;
    src[ftm_pkg::MAP_ACT] = act_status_i;
    src[ftm_pkg::MAP_OVR] = overrun_i;
    src[ftm_pkg::MAP_WM] = r.wm;
    src[ftm_pkg::MAP_RDY] = fifo_ready_i;
    src[ftm_pkg::MAP_DATA] = data_ready_i;
    next_r.pin = (|(src & r.map[6:0])) ^ r.map[ftm_pkg::MAP_POL_BIT];

    // Address phase; read data built from the updated values, INFO from the current ones
    next_r.dp_act = hsel_i && hready_i && htrans_i[1];
    next_r.dp_wr = hwrite_i;
    next_r.dp_addr = haddr_i;
    if (next_r.dp_act && !hwrite_i) begin
      case (haddr_i)
        A_CNT: rd[7:0] = next_r.cnt_lo;
        A_MAP: rd[7:0] = next_r.map;
        A_CTRL: rd[2:0] = {next_r.cnt_msb, next_r.mode};
        A_STAT: rd[ftm_pkg::EV_W-1:0] = next_r.stat;
        A_IEN: rd[ftm_pkg::EV_W-1:0] = next_r.ien;
        A_INFO: rd = {5'h00, r.post, 1'b0, r.pre, r.st};
        default: rd = 32'h0000_0000;
      endcase
      next_r.rdata = rd;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      r <= RST;
    end else if (ce_i) begin
      r <= next_r;
    end
  end

  // Zero wait state slave, always OKAY
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign hrdata_o = r.rdata;
  assign fifo_mode_o = r.mode;
  assign entry_target_o = ftm_tgt(r.cnt_msb, r.cnt_lo, axes_i);
  assign fill_stop_o = (r.st == ftm_pkg::ST_DONE);
  assign queue_level_reached_flag_o = r.wm;
  assign first_interrupt_pin_o = r.pin;
  assign irq_o = |(r.stat & r.ien);

  // Checks
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!nrst_i);

  sequence s_armed_hit;
    ce_i && r.mode == ftm_pkg::FTM_TRIG && r.st == ftm_pkg::ST_ARM && activity_i;
  endsequence

  sequence s_fill_end;
    ce_i && r.mode == ftm_pkg::FTM_TRIG && r.st == ftm_pkg::ST_FILL
      && (r.post + ENT_W'(sample_entry_i)) >= tgt;
  endsequence

  property p_trig_start;
    s_armed_hit |=> r.st == ftm_pkg::ST_FILL && r.post == '0;
  endproperty

  property p_fill_done;
    s_fill_end |=> r.st == ftm_pkg::ST_DONE ##0 queue_level_reached_flag_o;
  endproperty

  trig_start_a: assert property (p_trig_start)
    else $error("activity did not start the triggered fill");

  fill_done_a: assert property (p_fill_done)
    else $error("watermark not raised after triggered fill");

  wm_held_a: assert property (
    ce_i && r.mode == ftm_pkg::FTM_TRIG && fill_stop_o && !fifo_read_i
      |=> fill_stop_o && queue_level_reached_flag_o)
    else $error("triggered watermark dropped without a FIFO read");

  pre_cap_a: assert property (
    r.st == ftm_pkg::ST_ARM && ce_i && sample_entry_i && !activity_i
      && r.pre < tgt && r.mode == ftm_pkg::FTM_TRIG |=> r.pre == $past(r.pre) + ENT_W'(1))
    else $error("pre-event history did not advance");

  target_sets_a: assert property (
    entry_target_o == ENT_W'({r.cnt_msb, r.cnt_lo}) * ENT_W'(axes_i))
    else $error("entry target is not count times axes");

  reset_vals_a: assert property (
    $past(!nrst_i) |-> r.cnt_lo == 8'h80 && r.map == 8'h00 && !first_interrupt_pin_o)
    else $error("wrong register values after reset");

  pin_active_a: assert property (
    ce_i && (|(src & r.map[6:0])) |=> first_interrupt_pin_o == !$past(r.map[7]))
    else $error("first pin not asserted for a mapped source");

  pin_idle_a: assert property (
    ce_i && !(|(src & r.map[6:0])) |=> first_interrupt_pin_o == $past(r.map[7]))
    else $error("first pin asserted with no mapped source");

  sticky_set_a: assert property (
    ce_i && activity_i |=> r.stat[ftm_pkg::EV_ACT])
    else $error("activity event lost from status");

  mode_idle_a: assert property (
    ce_i && r.mode != ftm_pkg::FTM_TRIG |=> r.st == ftm_pkg::ST_IDLE)
    else $error("sequencer active outside triggered mode");

  awake_route_a: assert property (
    ce_i && awake_i && r.map[ftm_pkg::MAP_AWAKE]
      |=> first_interrupt_pin_o != $past(r.map[ftm_pkg::MAP_POL_BIT]))
    else $error("mapped awake status did not reach the first pin");

  inact_route_a: assert property (
    ce_i && inact_i && r.map[ftm_pkg::MAP_INACT]
      |=> first_interrupt_pin_o != $past(r.map[ftm_pkg::MAP_POL_BIT]))
    else $error("mapped inactivity status did not reach the first pin");

  act_route_a: assert property (
    ce_i && act_status_i && r.map[ftm_pkg::MAP_ACT]
      |=> first_interrupt_pin_o != $past(r.map[ftm_pkg::MAP_POL_BIT]))
    else $error("mapped activity status did not reach the first pin");

  ovr_route_a: assert property (
    ce_i && overrun_i && r.map[ftm_pkg::MAP_OVR]
      |=> first_interrupt_pin_o != $past(r.map[ftm_pkg::MAP_POL_BIT]))
    else $error("mapped overrun status did not reach the first pin");

  wm_route_a: assert property (
    ce_i && queue_level_reached_flag_o && r.map[ftm_pkg::MAP_WM]
      |=> first_interrupt_pin_o != $past(r.map[ftm_pkg::MAP_POL_BIT]))
    else $error("mapped watermark did not reach the first pin");

  rdy_route_a: assert property (
    ce_i && fifo_ready_i && r.map[ftm_pkg::MAP_RDY]
      |=> first_interrupt_pin_o != $past(r.map[ftm_pkg::MAP_POL_BIT]))
    else $error("mapped FIFO ready did not reach the first pin");

  data_route_a: assert property (
    ce_i && data_ready_i && r.map[ftm_pkg::MAP_DATA]
      |=> first_interrupt_pin_o != $past(r.map[ftm_pkg::MAP_POL_BIT]))
    else $error("mapped new-sample flag did not reach the first pin");

  map_write_a: assert property (
    ce_i && r.dp_act && r.dp_wr && r.dp_addr == A_MAP
      |=> r.map == $past(hwdata_i[7:0]))
    else $error("map register write did not land");

  cnt_write_a: assert property (
    ce_i && r.dp_act && r.dp_wr && r.dp_addr == A_CNT
      |=> r.cnt_lo == $past(hwdata_i[7:0]))
    else $error("count register write did not land");

  msb_write_a: assert property (
    ce_i && r.dp_act && r.dp_wr && r.dp_addr == A_CTRL
      |=> r.cnt_msb == $past(hwdata_i[ftm_pkg::CTRL_MSB_BIT]))
    else $error("ninth count bit write did not land");

endmodule

// ===== ftm_sample_src.sv
// Sensor-side model that writes axis entries into the FIFO
`timescale 1ns/1ps
module ftm_sample_src (
  input  wire logic clk_sys_i,
  output logic      sample_entry_o
);
  initial sample_entry_o = 1'b0;
  // One pulse is one axis entry; gap 0 gives a back-to-back burst
  task automatic send(input int n, input int gap);
    repeat (n) begin
      @(posedge clk_sys_i);
      sample_entry_o <= 1'b1;
      if (gap > 0) begin
        @(posedge clk_sys_i);
        sample_entry_o <= 1'b0;
        repeat (gap - 1) @(posedge clk_sys_i);
      end
    end
    @(posedge clk_sys_i);
    sample_entry_o <= 1'b0;
  endtask
endmodule

// ===== test_fifo_trigger_and_first_interrupt_pin_mapping.sv
// Self-checking bench for the FIFO trigger and first interrupt pin block
`timescale 1ns/1ps
module test_fifo_trigger_and_first_interrupt_pin_mapping;
  logic        clk_sys_i = 1'b0;
  logic        nrst_i    = 1'b0;
  logic        hsel_i    = 1'b0;
  logic [7:0]  haddr_i   = 8'h00;
  logic [1:0]  htrans_i  = 2'h0;
  logic        hwrite_i  = 1'b0;
  logic [31:0] hwdata_i  = 32'h0;
  logic        act       = 1'b0;
  logic        rd_fifo   = 1'b0;
  logic [6:0]  src       = 7'h00;
  logic [10:0] level     = 11'h000;
  logic [1:0]  axes      = 2'h3;
  logic        ce        = 1'b1;
  logic        hready;
  logic        hresp;
  logic [31:0] hrdata;
  logic        entry;
  logic [1:0]  mode;
  logic [10:0] target;
  logic        stop;
  logic        flag;
  logic        pin;
  logic        irq;
  logic [31:0] rd;
  int          err_count   = 0;
  int          check_count = 0;
  int          cycles      = 0;

  ftm_sample_src u_src (.clk_sys_i(clk_sys_i), .sample_entry_o(entry));
  ftm_core u_dut (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .ce_i(ce), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2),
    .hwdata_i(hwdata_i), .hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp),
    .hrdata_o(hrdata), .sample_entry_i(entry), .activity_i(act),
    .act_status_i(src[4]), .awake_i(src[6]), .inact_i(src[5]), .overrun_i(src[3]),
    .fifo_ready_i(src[1]), .data_ready_i(src[0]), .fifo_read_i(rd_fifo),
    .fifo_level_i(level), .axes_i(axes), .fifo_mode_o(mode), .entry_target_o(target),
    .fill_stop_o(stop), .queue_level_reached_flag_o(flag),
    .first_interrupt_pin_o(pin), .irq_o(irq)
  );

  always #2 clk_sys_i = ~clk_sys_i;
  // Whole run needs a few hundred cycles; anything past this is a hang
  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  task automatic wait_rdy();
    do @(posedge clk_sys_i); while (hready !== 1'b1);
  endtask
  // One single word transfer; read data lands in rd
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    hsel_i   <= 1'b1;
    htrans_i <= ftm_pkg::HTRANS_NONSEQ;
    haddr_i  <= {idx[5:0], 2'h0};
    hwrite_i <= wr;
    wait_rdy();
    htrans_i <= 2'h0;
    hwdata_i <= wd;
    wait_rdy();
    rd = hrdata;
  endtask
  task automatic pulse_act();
    act <= 1'b1;
    wt(1);
    act <= 1'b0;
  endtask

  task automatic t_regs();
    bus(0, ftm_pkg::CNT_LO_IDX, 0);
    chk("count_lo rst", 32'h80, rd);
    chk("hresp okay", 0, hresp);
    bus(0, ftm_pkg::MAP_IDX, 0);
    chk("map rst", 32'h00, rd);
    bus(1, ftm_pkg::CNT_LO_IDX, 32'h5A);
    bus(0, ftm_pkg::CNT_LO_IDX, 0);
    chk("count_lo rw", 32'h5A, rd);
    bus(1, ftm_pkg::MAP_IDX, 32'hC3);
    bus(0, ftm_pkg::MAP_IDX, 0);
    chk("map rw", 32'hC3, rd);
    bus(1, 8'h3F, 32'hFF);
    bus(0, 8'h3F, 0);
    chk("unmapped", 32'h0, rd);
  endtask
  // Each source except the watermark alone, then with the polarity flipped
  task automatic t_map();
    for (int b = 0; b < 7; b++) begin
      if (b != ftm_pkg::MAP_WM) begin
        bus(1, ftm_pkg::MAP_IDX, 32'h1 << b);
        src <= ~(7'h01 << b);
        wt(3);
        chk("pin unmapped src", 0, pin);
        src <= 7'h01 << b;
        wt(3);
        chk("pin mapped src", 1, pin);
        bus(1, ftm_pkg::MAP_IDX, 32'h80 | (32'h1 << b));
        wt(3);
        chk("pin low active", 0, pin);
      end
    end
    src <= 7'h00;
    wt(3);
    chk("pin low idle", 1, pin);
    bus(1, ftm_pkg::MAP_IDX, 0);
  endtask
  task automatic t_count();
    bus(1, ftm_pkg::CTRL_IDX, 32'h4);
    bus(1, ftm_pkg::CNT_LO_IDX, 32'hFF);
    wt(1);
    chk("target max", 1533, target);
    axes <= 2'h1;
    wt(1);
    chk("target 1 axis", 511, target);
    bus(1, ftm_pkg::CTRL_IDX, 32'h0);
    bus(1, ftm_pkg::CNT_LO_IDX, 32'h0);
    wt(1);
    chk("target zero", 0, target);
    axes <= 2'h3;
  endtask
  task automatic t_modes();
    bus(1, ftm_pkg::CNT_LO_IDX, 32'h02);
    level <= 11'd6;
    for (int m = 0; m < 3; m++) begin
      bus(1, ftm_pkg::CTRL_IDX, 32'h0);
      bus(1, ftm_pkg::CTRL_IDX, m);
      wt(3);
      chk("mode", m, mode);
      chk("flag at level", m != 0, flag);
      level <= 11'd5;
      wt(3);
      chk("flag below", 0, flag);
      level <= 11'd6;
    end
  endtask
  task automatic t_trig();
    bus(1, ftm_pkg::CTRL_IDX, 32'h0);
    bus(1, ftm_pkg::CTRL_IDX, 32'h3);
    bus(1, ftm_pkg::MAP_IDX, 32'h04);
    level <= 11'd0;
    wt(2);
    u_src.send(8, 0);
    bus(0, ftm_pkg::INFO_IDX, 0);
    chk("armed", 2, rd[3:0]);
    chk("pre hist", 6, rd[14:4]);
    pulse_act();
    u_src.send(5, 1);
    wt(2);
    chk("flag early", 0, flag);
    u_src.send(1, 1);
    wt(2);
    chk("flag done", 1, flag);
    chk("stop", 1, stop);
    chk("pin wm", 1, pin);
    pulse_act();
    u_src.send(6, 0);
    bus(0, ftm_pkg::INFO_IDX, 0);
    chk("no rerun", 8, rd[3:0]);
    rd_fifo <= 1'b1;
    wt(1);
    rd_fifo <= 1'b0;
    wt(3);
    chk("flag rearm", 0, flag);
    chk("pin rearm", 0, pin);
  endtask
  task automatic t_irq();
    bus(1, ftm_pkg::ICLR_IDX, 32'h7);
    bus(1, ftm_pkg::IEN_IDX, 32'h2);
    wt(1);
    chk("irq idle", 0, irq);
    pulse_act();
    wt(2);
    chk("irq set", 1, irq);
    bus(0, ftm_pkg::STAT_IDX, 0);
    chk("status act", 32'h2, rd);
    bus(1, ftm_pkg::IEN_IDX, 32'h0);
    wt(1);
    chk("irq masked", 0, irq);
    bus(1, ftm_pkg::ICLR_IDX, 32'h7);
    bus(0, ftm_pkg::STAT_IDX, 0);
    chk("status clr", 0, rd);
    bus(1, ftm_pkg::IEN_IDX, 32'h2);
    wt(1);
    chk("irq clr", 0, irq);
  endtask
  // Low enable must freeze the pin even while a mapped source rises
  task automatic t_ce();
    bus(1, ftm_pkg::MAP_IDX, 32'h01);
    wt(2);
    ce <= 1'b0;
    src <= 7'h01;
    wt(3);
    chk("pin frozen", 0, pin);
    ce <= 1'b1;
    wt(2);
    chk("pin resumed", 1, pin);
    src <= 7'h00;
    bus(1, ftm_pkg::MAP_IDX, 0);
  endtask

  initial begin
    wt(20);
    nrst_i <= 1'b1;
    wt(1);
    t_regs();
    t_map();
    t_count();
    t_modes();
    t_trig();
    t_irq();
    t_ce();
    finish_test();
  end
endmodule
